// >>> ctsr_pkg.sv
// Shared constants for the calibration trigger and status register bank.
// Assumes an 8-bit register port with byte offsets as listed here.
package ctsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_CAL_STATUS  = 8'h6A;
  localparam logic [7:0] OFF_PIN_CONFIG  = 8'h6B;
  localparam logic [7:0] OFF_SOFT_TRIG   = 8'h6C;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h70;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h71;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the calibration status register
  localparam int STAT_FG_COMPLETE_BIT = 0;
  localparam int STAT_BG_HALTED_BIT   = 1;
  localparam int STAT_CODE_LSB        = 2;
  localparam int STAT_CODE_MSB        = 4;
  localparam int STAT_CODE_W          = 3;

  // Field positions of the pin configuration register
  localparam int CFG_TRIG_SRC_BIT     = 0;
  localparam int CFG_PIN_SEL_LSB      = 1;
  localparam int CFG_PIN_SEL_MSB      = 2;

  // Field position of the software trigger register
  localparam int SOFT_TRIG_BIT        = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt event bits
  localparam int IRQ_FG_COMPLETE_BIT  = 0;
  localparam int IRQ_BG_HALTED_BIT    = 1;
  localparam int IRQ_BG_RESUMED_BIT   = 2;
  localparam int IRQ_ALARM_BIT        = 3;
  localparam int IRQ_W                = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0]       RST_PIN_SEL   = 2'h0;
  localparam logic             RST_TRIG_SRC  = 1'b0;
  localparam logic             RST_SOFT_TRIG = 1'b1;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Status pin source codes
  localparam logic [1:0] PIN_SEL_FG_COMPLETE = 2'h0;
  localparam logic [1:0] PIN_SEL_BG_HALTED   = 2'h1;
  localparam logic [1:0] PIN_SEL_ALARM       = 2'h2;
  localparam logic [1:0] PIN_SEL_LOW         = 2'h3;

  // Trigger source codes
  localparam logic TRIG_SRC_SOFTWARE = 1'b0;
  localparam logic TRIG_SRC_PIN      = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Background halt tracker states
  typedef enum logic [2:0] {
    HALT_WAIT_FG = 3'b001,
    HALT_RUNNING = 3'b010,
    HALT_STOPPED = 3'b100
  } ctsr_halt_t;

endpackage

// >>> ctsr_regs.sv
// Calibration trigger and status register bank with status pin routing.
// Assumes the calibration engine reports its events as one-cycle pulses on
// clk and that all inputs are synchronous to clk.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// - Status register read-only, code bits 4:2
// - Halted flag sets when stop reached
// - Halted flag clears when calibration resumes
// - Background off: halted follows foreground completion
// - Foreground flag high when done or skipped
// - Select field routes source to status pin
// - Source zero: software bit, pin ignored
// - Source one: pin used, software ignored
// - Software bit is trigger level, resets high
// - Triggered sleep: wake while trigger low
// - Background runs only when enabled
module ctsr_regs (
  // Clock, reset and enable
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       clkEn,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  output logic      [7:0] rdData_q,
  // Calibration engine reports
  input  wire logic [2:0] calStatusCode,
  input  wire logic       fgDonePulse,
  input  wire logic       fgSkipPulse,
  input  wire logic       calRestartPulse,
  input  wire logic       bgStopPulse,
  input  wire logic       bgResumePulse,
  input  wire logic       alarmIn,
  // Mode bits from other calibration registers
  input  wire logic       backgroundCalEnable,
  input  wire logic       triggeredSleepMode,
  // Trigger pin and derived controls
  input  wire logic       triggerInputPin,
  output logic            calTrigger_q,
  output logic            coreWakeRequest_q,
  output logic            backgroundRun_q,
  // Status pin and interrupt
  output logic            statusOutputPin_q,
  output logic            irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]                 pinSelect_q;
  logic                       triggerSourceSelect_q;
  logic                       softwareTriggerBit_q;
  logic [ctsr_pkg::IRQ_W-1:0] irqStatus_q;
  logic [ctsr_pkg::IRQ_W-1:0] irqMask_q;
  logic [ctsr_pkg::IRQ_W-1:0] irqEvents;
  logic [ctsr_pkg::IRQ_W-1:0] irqClear;
  logic [2:0]                 statusCode_q;
  logic                       fgComplete_q;
  logic                       alarm_q;
  logic                       alarmPrev_q;
  logic                       haltedPrev_q;
  logic                       fgCompletePrev_q;
  logic                       bgHalted;
  logic                       fgEvent;
  logic                       triggerSelected;
  logic                       pinSource;
  logic [7:0]                 statusByte;
  logic [7:0]                 configByte;
  logic [7:0]                 softTrigByte;
  logic [7:0]                 readMux;
  logic                       wrConfig;
  logic                       wrSoftTrig;
  logic                       wrIrqStatus;
  logic                       wrIrqMask;
  ctsr_pkg::ctsr_halt_t       haltState_q;
  ctsr_pkg::ctsr_halt_t       haltState_d;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; the status register has no write path at all
  assign wrConfig    = wrEn && (addr == ctsr_pkg::OFF_PIN_CONFIG);
  assign wrSoftTrig  = wrEn && (addr == ctsr_pkg::OFF_SOFT_TRIG);
  assign wrIrqStatus = wrEn && (addr == ctsr_pkg::OFF_IRQ_STATUS);
  assign wrIrqMask   = wrEn && (addr == ctsr_pkg::OFF_IRQ_MASK);

  // Pin configuration; reserved bits are not stored, so they read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      pinSelect_q           <= ctsr_pkg::RST_PIN_SEL;
      triggerSourceSelect_q <= ctsr_pkg::RST_TRIG_SRC;
    end else if (clkEn && wrConfig) begin
      pinSelect_q           <= wrData[ctsr_pkg::CFG_PIN_SEL_MSB:ctsr_pkg::CFG_PIN_SEL_LSB];
      triggerSourceSelect_q <= wrData[ctsr_pkg::CFG_TRIG_SRC_BIT];
    end
  end

  // Software trigger level, high after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      softwareTriggerBit_q <= ctsr_pkg::RST_SOFT_TRIG;
    end else if (clkEn && wrSoftTrig) begin
      softwareTriggerBit_q <= wrData[ctsr_pkg::SOFT_TRIG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine status code is sampled for a stable readback, alarm for pin and interrupt
  always_ff @(posedge clk) begin
    if (srst) begin
      statusCode_q <= 3'h0;
      alarm_q      <= 1'b0;
    end else if (clkEn) begin
      statusCode_q <= calStatusCode;
      alarm_q      <= alarmIn;
    end
  end

  // Foreground completion: done or skipped both count
  assign fgEvent = fgDonePulse || fgSkipPulse;

  // Set wins over restart so a finish is never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      fgComplete_q <= 1'b0;
    end else if (clkEn) begin
      if (fgEvent) begin
        fgComplete_q <= 1'b1;
      end else if (calRestartPulse) begin
        fgComplete_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Background halt tracker
  always_comb begin
    haltState_d = haltState_q;
    case (haltState_q)
      ctsr_pkg::HALT_WAIT_FG: begin
        if (fgEvent) begin
          if (backgroundCalEnable) begin
            haltState_d = ctsr_pkg::HALT_RUNNING;
          end else begin
            haltState_d = ctsr_pkg::HALT_STOPPED;
          end
        end
      end
      ctsr_pkg::HALT_RUNNING: begin
        if (bgStopPulse) begin
          haltState_d = ctsr_pkg::HALT_STOPPED;
        end else if (!backgroundCalEnable) begin
          haltState_d = ctsr_pkg::HALT_STOPPED;
        end else if (calRestartPulse) begin
          haltState_d = ctsr_pkg::HALT_WAIT_FG;
        end
      end
      ctsr_pkg::HALT_STOPPED: begin
        if (calRestartPulse && !fgEvent) begin
          haltState_d = ctsr_pkg::HALT_WAIT_FG;
        end else if (bgResumePulse && backgroundCalEnable) begin
          haltState_d = ctsr_pkg::HALT_RUNNING;
        end
      end
      default: begin
        haltState_d = ctsr_pkg::HALT_WAIT_FG;
      end
    endcase
  end

  // Tracker register
  always_ff @(posedge clk) begin
    if (srst) begin
      haltState_q <= ctsr_pkg::HALT_WAIT_FG;
    end else if (clkEn) begin
      haltState_q <= haltState_d;
    end
  end

  assign bgHalted = (haltState_q == ctsr_pkg::HALT_STOPPED);

  // Background run level toward the engine
  always_ff @(posedge clk) begin
    if (srst) begin
      backgroundRun_q <= 1'b0;
    end else if (clkEn) begin
      backgroundRun_q <= backgroundCalEnable &&
                         (haltState_d == ctsr_pkg::HALT_RUNNING);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source; the unselected source has no path at all
  always_comb begin
    if (triggerSourceSelect_q == ctsr_pkg::TRIG_SRC_PIN) begin
      triggerSelected = triggerInputPin;
    end else begin
      triggerSelected = softwareTriggerBit_q;
    end
  end

  // Registered trigger and wake request
  always_ff @(posedge clk) begin
    if (srst) begin
      calTrigger_q      <= ctsr_pkg::RST_SOFT_TRIG;
      coreWakeRequest_q <= 1'b0;
    end else if (clkEn) begin
      calTrigger_q      <= triggerSelected;
      coreWakeRequest_q <= triggeredSleepMode && !triggerSelected;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status pin routing
  always_comb begin
    case (pinSelect_q)
      ctsr_pkg::PIN_SEL_FG_COMPLETE: pinSource = fgComplete_q;
      ctsr_pkg::PIN_SEL_BG_HALTED:   pinSource = bgHalted;
      ctsr_pkg::PIN_SEL_ALARM:       pinSource = alarm_q;
      ctsr_pkg::PIN_SEL_LOW:         pinSource = 1'b0;
      default:                       pinSource = 1'b0;
    endcase
  end

  // One flop keeps the pin glitch free, at one cycle of lag
  always_ff @(posedge clk) begin
    if (srst) begin
      statusOutputPin_q <= 1'b0;
    end else if (clkEn) begin
      statusOutputPin_q <= pinSource;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge history for interrupt events
  always_ff @(posedge clk) begin
    if (srst) begin
      fgCompletePrev_q <= 1'b0;
      haltedPrev_q     <= 1'b0;
      alarmPrev_q      <= 1'b0;
    end else if (clkEn) begin
      fgCompletePrev_q <= fgComplete_q;
      haltedPrev_q     <= bgHalted;
      alarmPrev_q      <= alarm_q;
    end
  end

  // Event pulses
  always_comb begin
    irqEvents = '0;
    irqEvents[ctsr_pkg::IRQ_FG_COMPLETE_BIT] = fgComplete_q && !fgCompletePrev_q;
    irqEvents[ctsr_pkg::IRQ_BG_HALTED_BIT]   = bgHalted && !haltedPrev_q;
    irqEvents[ctsr_pkg::IRQ_BG_RESUMED_BIT]  = !bgHalted && haltedPrev_q;
    irqEvents[ctsr_pkg::IRQ_ALARM_BIT]       = alarm_q && !alarmPrev_q;
  end

  assign irqClear = wrIrqStatus ? wrData[ctsr_pkg::IRQ_W-1:0] : '0;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      irqStatus_q <= '0;
    end else if (clkEn) begin
      irqStatus_q <= (irqStatus_q & ~irqClear) | irqEvents;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (srst) begin
      irqMask_q <= ctsr_pkg::RST_IRQ_MASK;
    end else if (clkEn && wrIrqMask) begin
      irqMask_q <= wrData[ctsr_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt from the next status value, so it needs no extra lag
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else if (clkEn) begin
      irq_q <= |(((irqStatus_q & ~irqClear) | irqEvents) & irqMask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback images; unstored bits read as zero
  always_comb begin
    statusByte = 8'h00;
    statusByte[ctsr_pkg::STAT_CODE_MSB:ctsr_pkg::STAT_CODE_LSB] = statusCode_q;
    statusByte[ctsr_pkg::STAT_BG_HALTED_BIT]   = bgHalted;
    statusByte[ctsr_pkg::STAT_FG_COMPLETE_BIT] = fgComplete_q;
  end

  always_comb begin
    configByte = 8'h00;
    configByte[ctsr_pkg::CFG_PIN_SEL_MSB:ctsr_pkg::CFG_PIN_SEL_LSB] = pinSelect_q;
    configByte[ctsr_pkg::CFG_TRIG_SRC_BIT] = triggerSourceSelect_q;
    softTrigByte = 8'h00;
    softTrigByte[ctsr_pkg::SOFT_TRIG_BIT] = softwareTriggerBit_q;
  end

  // Read decode; unmapped offsets return zero
  always_comb begin
    case (addr)
      ctsr_pkg::OFF_CAL_STATUS: readMux = statusByte;
      ctsr_pkg::OFF_PIN_CONFIG: readMux = configByte;
      ctsr_pkg::OFF_SOFT_TRIG:  readMux = softTrigByte;
      ctsr_pkg::OFF_IRQ_STATUS: readMux = {4'h0, irqStatus_q};
      ctsr_pkg::OFF_IRQ_MASK:   readMux = {4'h0, irqMask_q};
      default:                  readMux = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_q <= 8'h00;
    end else if (clkEn) begin
      rdData_q <= rdEn ? readMux : 8'h00;
    end
  end

endmodule

// >>> ctsr_partner.sv
// System logic beside the bank: drives the external trigger pin.
// Assumes the bench commands the level; the pin moves only after a clock edge.
`timescale 1ns/1ps
module ctsr_partner (
  // Clock
  input  wire logic clk,
  // Commanded trigger level
  input  wire logic trigLevel,
  // Trigger pin towards the bank
  output logic      triggerInputPin
);
  // Registered, so the pin never changes in the bank's sampling step
  always_ff @(posedge clk) begin
    triggerInputPin <= trigLevel;
  end
endmodule

// >>> ctsr_regs_properties.sv
// Port-level checks for the calibration trigger and status bank.
// Assumes it is bound to ctsr_regs and sees only that module's ports.
`timescale 1ns/1ps
module ctsr_regs_properties (
  // Clock and register port
  input wire logic       clk, srst, clkEn, wrEn, rdEn,
  input wire logic [7:0] addr, wrData, rdData_q,
  // Engine reports and mode bits
  input wire logic [2:0] calStatusCode,
  input wire logic       fgDonePulse, fgSkipPulse, calRestartPulse, bgStopPulse,
  input wire logic       bgResumePulse, alarmIn, backgroundCalEnable, triggeredSleepMode,
  // Pins and derived outputs
  input wire logic       triggerInputPin, calTrigger_q, coreWakeRequest_q,
  input wire logic       backgroundRun_q, statusOutputPin_q, irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [1:0] pinSel_q;
  logic       src_q;
  logic       soft_q;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the stored selects; the checker has no view inside
  always_ff @(posedge clk) begin
    if (srst) begin
      pinSel_q <= ctsr_pkg::RST_PIN_SEL;
      src_q    <= ctsr_pkg::RST_TRIG_SRC;
      soft_q   <= ctsr_pkg::RST_SOFT_TRIG;
    end else if (clkEn && wrEn && addr == ctsr_pkg::OFF_PIN_CONFIG) begin
      pinSel_q <= wrData[2:1];
      src_q    <= wrData[0];
    end else if (clkEn && wrEn && addr == ctsr_pkg::OFF_SOFT_TRIG) begin
      soft_q   <= wrData[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  src_sw_a: assert property (clkEn && !src_q |=> calTrigger_q == $past(soft_q))
    else $error("trigger not taken from software bit");
  src_pin_a: assert property (clkEn && src_q |=> calTrigger_q == $past(triggerInputPin))
    else $error("trigger not taken from pin");
  wake_off_a: assert property (clkEn && !triggeredSleepMode |=> !coreWakeRequest_q)
    else $error("wake request outside triggered sleep");
  rd_idle_a: assert property (clkEn && !rdEn |=> rdData_q == 8'h00)
    else $error("read data outside read answer");
  stat_code_a: assert property (clkEn && rdEn && addr == ctsr_pkg::OFF_CAL_STATUS
    && $stable(calStatusCode) |=> rdData_q[7:2] == {3'h0, $past(calStatusCode)})
    else $error("status code or reserved bits wrong");
  pin_low_a: assert property (clkEn && pinSel_q == ctsr_pkg::PIN_SEL_LOW
    |=> !statusOutputPin_q) else $error("status pin not low");
  pin_alarm_a: assert property ((pinSel_q == ctsr_pkg::PIN_SEL_ALARM)[*2]
    |=> statusOutputPin_q == $past(alarmIn, 2)) else $error("status pin not alarm");
  fg_pin_a: assert property ((fgDonePulse || fgSkipPulse) && clkEn
    && pinSel_q == 2'h0 ##1 pinSel_q == 2'h0 |=> statusOutputPin_q)
    else $error("foreground flag not set");
  halt_nobg_a: assert property (fgDonePulse && !backgroundCalEnable && clkEn
    && pinSel_q == 2'h1 ##1 pinSel_q == 2'h1 |=> statusOutputPin_q)
    else $error("halted flag not set with background off");
  halt_clr_a: assert property (bgResumePulse && backgroundCalEnable && clkEn
    && !(fgDonePulse || fgSkipPulse || bgStopPulse) && pinSel_q == 2'h1
    ##1 pinSel_q == 2'h1 |=> !statusOutputPin_q) else $error("halted flag kept on resume");
endmodule

bind ctsr_regs ctsr_regs_properties chk (.clk, .srst, .clkEn, .wrEn, .rdEn, .addr, .wrData,
  .rdData_q, .calStatusCode, .fgDonePulse, .fgSkipPulse, .calRestartPulse, .bgStopPulse,
  .bgResumePulse, .alarmIn, .backgroundCalEnable, .triggeredSleepMode, .triggerInputPin,
  .calTrigger_q, .coreWakeRequest_q, .backgroundRun_q, .statusOutputPin_q, .irq_q);

// >>> ctsr_regs_test.sv
// Self-checking bench for the calibration trigger and status bank.
// Assumes the checker is bound by its own file; clkEn high but for one freeze test.
`timescale 1ns/1ps
module ctsr_regs_test;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} ctsr_row_t;
  logic       clk = 1'b0, srst = 1'b1, clkEn = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
  logic [7:0] addr = 8'h00, wrData = 8'h00, rdData_q;
  logic [2:0] calStatusCode = 3'h0;
  logic       fgDonePulse = 1'b0, fgSkipPulse = 1'b0, calRestartPulse = 1'b0;
  logic       bgStopPulse = 1'b0, bgResumePulse = 1'b0, alarmIn = 1'b0, trigLevel = 1'b1;
  logic       backgroundCalEnable = 1'b0, triggeredSleepMode = 1'b0, triggerInputPin;
  logic       calTrigger_q, coreWakeRequest_q, backgroundRun_q, statusOutputPin_q, irq_q;
  int         err_total = 0, cmp_count = 0;
  // Register rows: optional write, then read back; reserved fields kept at default
  ctsr_row_t  rows [10] = '{'{1'b0, 8'h6A, 8'h00, 8'h00}, '{1'b0, 8'h6B, 8'h00, 8'h00},
    '{1'b0, 8'h6C, 8'h00, 8'h01}, '{1'b0, 8'h55, 8'h00, 8'h00}, '{1'b1, 8'h6B, 8'h07, 8'h07},
    '{1'b1, 8'h6B, 8'h00, 8'h00}, '{1'b1, 8'h6A, 8'hFF, 8'h00}, '{1'b1, 8'h6C, 8'h00, 8'h00},
    '{1'b1, 8'h6C, 8'h01, 8'h01}, '{1'b1, 8'h55, 8'hAA, 8'h00}};
  ctsr_regs uut (.clk, .srst, .clkEn, .addr, .wrData, .wrEn, .rdEn, .rdData_q, .calStatusCode,
    .fgDonePulse, .fgSkipPulse, .calRestartPulse, .bgStopPulse, .bgResumePulse, .alarmIn,
    .backgroundCalEnable, .triggeredSleepMode, .triggerInputPin, .calTrigger_q,
    .coreWakeRequest_q, .backgroundRun_q, .statusOutputPin_q, .irq_q);
  ctsr_partner peer (.clk, .trigLevel, .triggerInputPin);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the tests need well under a thousand cycles
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 4000);
    err_total++;
    summarize();
  end
  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // Bus cycles: strobes one cycle, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk8(rdData_q, e);
  endtask
  // Engine pulse: {done, skip, restart, stop, resume}
  task automatic ev(input logic [4:0] p);
    @(posedge clk);
    {fgDonePulse, fgSkipPulse, calRestartPulse, bgStopPulse, bgResumePulse} <= p;
    @(posedge clk);
    {fgDonePulse, fgSkipPulse, calRestartPulse, bgStopPulse, bgResumePulse} <= 5'h00;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1 chk1(calTrigger_q, 1'b1);
    chk1(statusOutputPin_q | irq_q | coreWakeRequest_q | backgroundRun_q, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge clk) calStatusCode <= 3'(c);
      rd(ctsr_pkg::OFF_CAL_STATUS, {3'h0, 3'(c), 2'h0});
    end
    @(posedge clk) trigLevel <= 1'b0;
    wr(ctsr_pkg::OFF_SOFT_TRIG, 8'h00);
    tick(3);
    chk1(calTrigger_q, 1'b0);
    @(posedge clk) trigLevel <= 1'b1;
    tick(3);
    chk1(calTrigger_q, 1'b0);
    wr(ctsr_pkg::OFF_PIN_CONFIG, 8'h01);
    tick(2);
    chk1(calTrigger_q, 1'b1);
    wr(ctsr_pkg::OFF_SOFT_TRIG, 8'h01);
    @(posedge clk) trigLevel <= 1'b0;
    triggeredSleepMode <= 1'b1;
    tick(3);
    chk1(calTrigger_q, 1'b0);
    chk1(coreWakeRequest_q, 1'b1);
    @(posedge clk) trigLevel <= 1'b1;
    tick(3);
    chk1(coreWakeRequest_q, 1'b0);
    @(posedge clk) alarmIn <= 1'b1;
    wr(ctsr_pkg::OFF_PIN_CONFIG, 8'h04);
    tick(1);
    chk1(statusOutputPin_q, 1'b1);
    wr(ctsr_pkg::OFF_PIN_CONFIG, 8'h06);
    tick(1);
    chk1(statusOutputPin_q, 1'b0);
    wr(ctsr_pkg::OFF_PIN_CONFIG, 8'h00);
    ev(5'h10);
    tick(1);
    chk1(statusOutputPin_q, 1'b1);
    wr(ctsr_pkg::OFF_PIN_CONFIG, 8'h02);
    tick(1);
    chk1(statusOutputPin_q, 1'b1);
    @(posedge clk) backgroundCalEnable <= 1'b1;
    ev(5'h04);
    ev(5'h08);
    tick(1);
    chk1(statusOutputPin_q, 1'b0);
    chk1(backgroundRun_q, 1'b1);
    ev(5'h02);
    tick(1);
    chk1(statusOutputPin_q, 1'b1);
    rd(ctsr_pkg::OFF_CAL_STATUS, 8'h1F);
    ev(5'h01);
    tick(1);
    chk1(statusOutputPin_q, 1'b0);
    @(posedge clk) backgroundCalEnable <= 1'b0;
    tick(2);
    chk1(backgroundRun_q, 1'b0);
    // Interrupt: clear, unmask, raise, mask, clear by writing one
    wr(ctsr_pkg::OFF_IRQ_STATUS, 8'h0F);
    wr(ctsr_pkg::OFF_IRQ_MASK, 8'h01);
    ev(5'h04);
    ev(5'h10);
    tick(2);
    chk1(irq_q, 1'b1);
    rd(ctsr_pkg::OFF_IRQ_STATUS, 8'h07);
    wr(ctsr_pkg::OFF_IRQ_MASK, 8'h00);
    tick(1);
    chk1(irq_q, 1'b0);
    wr(ctsr_pkg::OFF_IRQ_MASK, 8'h01);
    tick(1);
    chk1(irq_q, 1'b1);
    wr(ctsr_pkg::OFF_IRQ_STATUS, 8'h01);
    tick(2);
    chk1(irq_q, 1'b0);
    // Clock enable low: a write must leave the software bit untouched
    @(posedge clk) clkEn <= 1'b0;
    wr(ctsr_pkg::OFF_SOFT_TRIG, 8'h00);
    @(posedge clk) clkEn <= 1'b1;
    rd(ctsr_pkg::OFF_SOFT_TRIG, 8'h01);
    // Second reset in mid-run must restore the high software trigger
    wr(ctsr_pkg::OFF_SOFT_TRIG, 8'h00);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    rd(ctsr_pkg::OFF_SOFT_TRIG, 8'h01);
    summarize();
  end
endmodule
